//--- hw/sleep_filter.sv
// sleep/reset pin filter: synchronises the pin and reports low time
// assumes the pin is asynchronous to mclk_in
`timescale 1ns/1ps
`include "stepper_ctl_defines.svh"

module sleep_filter (
   // clock and power-up reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // pin
   input wire logic sleep_reset_pin_in,
   // status
   output logic pin_low_out,
   output logic long_low_out
);

   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] LIMIT =
      CNT_W'(`SLEEP_FILTER_CYCLES);

   logic sync1;
   logic sync2;
   logic [CNT_W-1:0] cnt;
   logic long_low;
   logic [CNT_W-1:0] next_cnt;
   logic next_long_low;

   always_comb begin
      next_cnt = cnt;
      next_long_low = long_low;
      if (sync2) begin
         next_cnt = '0;
         next_long_low = 1'b0;
      end else if (cnt < LIMIT) begin
         next_cnt = cnt + CNT_W'(1);
      end else begin
         next_long_low = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         cnt <= '0;
         long_low <= 1'b0;
      end else begin
         sync1 <= sleep_reset_pin_in;
         sync2 <= sync1;
         cnt <= next_cnt;
         long_low <= next_long_low;
      end
   end

   assign pin_low_out = ~sync2;
   assign long_low_out = long_low;

endmodule

//--- hw/stepper_stop_sleep.sv
// stop, sleep/reset and microstep position logic of a stepper driver
// assumes one 200 MHz clock; all pins are asynchronous and synchronised
// Operation
// [R1] bridge disable pin high turns all bridge transistors off, freewheel
// [R2] with halt flag set, encoder A high stops stepping into hold state
// [R3] sleep pin low beyond 30 us resets chip, shown on diag outputs
// [R4] sleep pin low pulses under 30 us are ignored
// [R5] sleep pin held low keeps device in standby, supplies off
// [R6] reset and standby restore defaults and keep bridges off
// [R7] host reprograms after reset, ideally with bridges disabled
// [R8] host avoids sleep or reset while motor runs fast
// [R9] power-up clears all state including the microstep position
// [R10] position 128, 384, 640, 896 marks a fullstep position
// [R11] first fullstep after n/2 steps, then every n steps
// [R12] each step moves position by 256 over the resolution
// [R13] step with direction 0 increases the position
// [R14] position reads zero at multiples of four times resolution
// [R15] host restores phase by stepping before enabling bridges
// [R16] decimal mode: integer upper 16 bits, ten-thousandths lower 16
// [R17] signed 16.16 scale added or subtracted per quadrature edge
// [R18] microstep position is 10 bits addressing the full wave
// [R19] encoder A and bridge disable are synchronised before use
`timescale 1ns/1ps
`include "stepper_ctl_defines.svh"

module stepper_stop_sleep (
   // clock and power-up reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // pins from the host
   input wire logic bridge_disable_pin_in,
   input wire logic sleep_reset_pin_in,
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic encoder_a_input_in,
   input wire logic encoder_b_in,
   // configuration written by the host
   input wire logic cfg_we_in,
   input wire stepper_ctl_pkg::config_t cfg_in,
   // bridge control
   output logic bridge_on_out,
   output logic hold_current_out,
   output logic [4:0] current_level_out,
   // status
   output logic [9:0] microstep_position_out,
   output logic fullstep_out,
   output logic [31:0] enc_count_out,
   output logic standby_out,
   output logic diag_reset_out,
   output stepper_ctl_pkg::drive_state_t state_out
);

   localparam logic [4:0] RUN_CURRENT = 5'h1f;

   // two-stage synchronisers for asynchronous pins
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] sync3;
   logic dis_s;
   logic encoder_a_input_s;
   logic encb_s;
   logic step_s;
   logic dir_s;
   logic step_rise;
   logic encoder_a_input_edge;
   logic encb_edge;

   logic pin_low;
   logic long_low;
   logic soft_rst;

   stepper_ctl_pkg::config_t cfg;
   stepper_ctl_pkg::config_t next_cfg;
   stepper_ctl_pkg::drive_state_t state;
   stepper_ctl_pkg::drive_state_t next_state;
   logic [`MSPOS_W-1:0] mspos;
   logic [`MSPOS_W-1:0] next_mspos;
   logic [`MSPOS_W-1:0] step_inc;
   logic [31:0] enc;
   logic [31:0] next_enc;
   logic [31:0] scale_bin;
   logic [19:0] tick;
   logic [19:0] next_tick;
   logic [3:0] hold_cnt;
   logic [3:0] next_hold_cnt;
   logic halted;

   sleep_filter u_sleep_filter (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .sleep_reset_pin_in(sleep_reset_pin_in),
      .pin_low_out(pin_low),
      .long_low_out(long_low)
   );

   // short lows never reach the core state
   assign soft_rst = long_low; // see [R3] see [R4]

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1 <= 5'h01;
         sync2 <= 5'h01;
         sync3 <= 5'h01;
      end else begin
         sync1 <= {dir_in, step_in, encoder_b_in, encoder_a_input_in,
            bridge_disable_pin_in}; // see [R19]
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign dis_s = sync2[0];
   assign encoder_a_input_s = sync2[1];
   assign encb_s = sync2[2];
   assign step_s = sync2[3];
   assign dir_s = sync2[4];
   assign step_rise = step_s & ~sync3[3];
   assign encoder_a_input_edge = encoder_a_input_s ^ sync3[1];
   assign encb_edge = encb_s ^ sync3[2];

   assign halted = cfg.step_halt_en & encoder_a_input_s; // see [R2]

   // step is 1 << resolution code; unused codes fall back to finest
   always_comb begin
      if (cfg.mres > stepper_ctl_pkg::MRES_1) begin
         step_inc = 10'h001;
      end else begin
         step_inc = 10'h001 << cfg.mres; // see [R12]
      end
   end

   // decimal fraction is scaled to 1/65536 units before accumulation
   always_comb begin
      logic [31:0] frac;
      frac = 32'h0000_0000;
      if (cfg.decimal_mode) begin
         frac = (32'(cfg.enc_scale[15:0]) << 16) / 32'h0000_2710;
         scale_bin = {cfg.enc_scale[31:16], frac[15:0]}; // see [R16]
      end else begin
         scale_bin = cfg.enc_scale;
      end
   end

   always_comb begin
      next_cfg = cfg;
      next_mspos = mspos;
      next_enc = enc;
      next_state = state;
      next_tick = tick + 20'h0_0001;
      next_hold_cnt = hold_cnt;
      if (soft_rst) begin
         // reset and standby clear everything, bridges off
         next_cfg = '0; // see [R6] see [R5]
         next_mspos = `MSPOS_RESET;
         next_enc = `ENC_RESET;
         next_state = stepper_ctl_pkg::ST_OFF;
         next_tick = '0;
         next_hold_cnt = '0;
      end else begin
         if (cfg_we_in) begin
            next_cfg = cfg_in;
         end
         // position counts even with bridges off so phase can be restored
         if (step_rise && !halted) begin
            if (!dir_s) begin
               next_mspos = mspos + step_inc; // see [R13] see [R11]
            end else begin
               next_mspos = mspos - step_inc;
            end
         end
         if (encoder_a_input_edge || encb_edge) begin
            // direction from quadrature phase, scale is signed 16.16
            if (encoder_a_input_edge ^ (encoder_a_input_s == encb_s)) begin
               next_enc = enc + scale_bin; // see [R17]
            end else begin
               next_enc = enc - scale_bin;
            end
         end
         case (state)
            stepper_ctl_pkg::ST_OFF: begin
               if (!dis_s) begin
                  next_state = stepper_ctl_pkg::ST_RUN;
               end
            end
            stepper_ctl_pkg::ST_RUN: begin
               if (dis_s) begin
                  next_state = stepper_ctl_pkg::ST_OFF; // see [R1]
               end else if (halted) begin
                  next_state = stepper_ctl_pkg::ST_HOLD; // see [R2]
                  next_hold_cnt = cfg.hold_ramp_delay;
                  next_tick = '0;
               end
            end
            stepper_ctl_pkg::ST_HOLD: begin
               if (dis_s) begin
                  next_state = stepper_ctl_pkg::ST_OFF; // see [R1]
               end else if (!halted) begin
                  next_state = stepper_ctl_pkg::ST_RUN;
               end else if (tick == `HOLD_TICK_CYCLES) begin
                  next_tick = '0;
                  if (hold_cnt != 4'h0) begin
                     next_hold_cnt = hold_cnt - 4'h1;
                  end
               end
            end
            default: begin
               next_state = stepper_ctl_pkg::ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg <= '0; // see [R9]
         mspos <= `MSPOS_RESET; // see [R9] see [R18]
         enc <= `ENC_RESET;
         state <= stepper_ctl_pkg::ST_OFF;
         tick <= '0;
         hold_cnt <= '0;
         bridge_on_out <= 1'b0;
         hold_current_out <= 1'b0;
         current_level_out <= 5'h00;
         fullstep_out <= 1'b0;
         standby_out <= 1'b0;
         diag_reset_out <= 1'b1;
      end else begin
         cfg <= next_cfg;
         mspos <= next_mspos;
         enc <= next_enc;
         state <= next_state;
         tick <= next_tick;
         hold_cnt <= next_hold_cnt;
         // pin checked directly so disable acts even mid-transition
         bridge_on_out <= (next_state != stepper_ctl_pkg::ST_OFF) &&
            !dis_s && !soft_rst; // see [R1] see [R6]
         hold_current_out <= next_state == stepper_ctl_pkg::ST_HOLD;
         if (next_state == stepper_ctl_pkg::ST_HOLD &&
            next_hold_cnt == 4'h0) begin
            current_level_out <= next_cfg.standstill_current;
         end else if (next_state == stepper_ctl_pkg::ST_OFF) begin
            current_level_out <= 5'h00;
         end else begin
            current_level_out <= RUN_CURRENT;
         end
         // low byte 0x80 covers 128/384/640/896
         fullstep_out <=
            next_mspos[7:0] == 8'(`FULLSTEP_POS0); // see [R10]
         standby_out <= soft_rst && pin_low; // see [R5]
         diag_reset_out <= soft_rst; // see [R3]
      end
   end

   // zero at multiples of four full steps since mod 1024 wraps there
   assign microstep_position_out = mspos; // see [R14]
   assign enc_count_out = enc;
   assign state_out = state;

endmodule

//--- shared/stepper_ctl_defines.svh
// constants for the stop, sleep and microstep position block
// assumes a 200 MHz core clock
`ifndef STEPPER_CTL_DEFINES_SVH
`define STEPPER_CTL_DEFINES_SVH

`define CLK_PERIOD_PS 5000
`define SLEEP_FILTER_NS 30000
// least time: round up to whole cycles
`define SLEEP_FILTER_CYCLES \
   ((`SLEEP_FILTER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MSPOS_W 10
`define MSPOS_RESET 10'h000
`define FULLSTEP_POS0 10'h080
`define ENC_W 32
`define ENC_RESET 32'h0000_0000
`define DEC_FRAC_LIMIT 16'h2710
`define HOLD_DELAY_W 4
`define HOLD_TICK_CYCLES 20'h3_ffff

`endif

//--- shared/stepper_ctl_pkg.sv
// types for the stop, sleep and microstep position block
// assumes the defines header is compiled alongside
package stepper_ctl_pkg;

   typedef enum logic [3:0] {
      MRES_256 = 4'h0,
      MRES_128 = 4'h1,
      MRES_64 = 4'h2,
      MRES_32 = 4'h3,
      MRES_16 = 4'h4,
      MRES_8 = 4'h5,
      MRES_4 = 4'h6,
      MRES_2 = 4'h7,
      MRES_1 = 4'h8
   } mres_t;

   typedef struct packed {
      logic step_halt_en;
      logic decimal_mode;
      mres_t mres;
      logic [4:0] standstill_current;
      logic [3:0] hold_ramp_delay;
      logic [31:0] enc_scale;
   } config_t;

   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_RUN = 3'b010,
      ST_HOLD = 3'b100
   } drive_state_t;

endpackage

//--- verif/host_model.sv
// host model: step, direction and bridge disable pins
// assumes mclk_in runs; pins change 1 ns after rising edges
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic mclk_in,
   // pins toward the driver
   output logic step_out,
   output logic dir_out,
   output logic bridge_disable_out
);
   initial {step_out, dir_out, bridge_disable_out} = 3'b001;
   // 3 cycles per level, clear of the 2 cycle floor
   task automatic move(input int n, input logic d);
      dir_out = d;
      repeat (2 * n) begin
         repeat (3) @(posedge mclk_in);
         #1 step_out = ~step_out;
      end
   endtask
   // phase restore steps are issued before this enables
   task automatic bridges(input logic off);
      @(posedge mclk_in);
      #1 bridge_disable_out = off;
   endtask
endmodule

//--- verif/stepper_stop_sleep_properties.sv
// assertions on the stop, sleep and position block ports
// assumes a bind onto stepper_stop_sleep, one clock
`timescale 1ns/1ps
module stepper_props (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // inputs
   input wire logic bridge_disable_pin_in,
   input wire logic sleep_reset_pin_in,
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic encoder_a_input_in,
   input wire logic encoder_b_in,
   input wire logic cfg_we_in,
   input wire stepper_ctl_pkg::config_t cfg_in,
   // outputs
   input wire logic bridge_on_out,
   input wire logic hold_current_out,
   input wire logic [4:0] current_level_out,
   input wire logic [9:0] microstep_position_out,
   input wire logic fullstep_out,
   input wire logic [31:0] enc_count_out,
   input wire logic standby_out,
   input wire logic diag_reset_out,
   input wire stepper_ctl_pkg::drive_state_t state_out
);
   localparam int LONG_LOW = 6000;
   logic [15:0] low_cnt;
   logic halt_q;
   logic [3:0] mres_q;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   // config shadow; a chip reset wipes it as well
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_cnt <= 16'h0000;
         {halt_q, mres_q} <= 5'h00;
      end else begin
         low_cnt <= sleep_reset_pin_in ? 16'h0000 : low_cnt + 16'h0001;
         if (diag_reset_out)
            {halt_q, mres_q} <= 5'h00;
         else if (cfg_we_in)
            {halt_q, mres_q} <= {cfg_in.step_halt_en, cfg_in.mres};
      end
   end
   sequence moved;
      $changed(microstep_position_out) && !diag_reset_out &&
         !$past(diag_reset_out);
   endsequence
   a_bridge_off: assert property (
      bridge_disable_pin_in [*5] |-> !bridge_on_out &&
      current_level_out == 5'h00) else $error("bridge on while disabled");
   a_halt_stops: assert property (
      (halt_q && encoder_a_input_in) [*6] |->
      ($stable(microstep_position_out) || diag_reset_out) &&
      state_out != stepper_ctl_pkg::ST_RUN) else $error("step in halt");
   a_long_low: assert property (
      low_cnt == LONG_LOW + 10 |->
      diag_reset_out && standby_out) else $error("long low ignored");
   a_short_low: assert property (
      $rose(diag_reset_out) |->
      low_cnt >= LONG_LOW) else $error("short low caused reset");
   a_reset_clears: assert property (
      diag_reset_out [*2] |->
      microstep_position_out == 10'h000 && !bridge_on_out)
      else $error("state kept through reset");
   a_fullstep_flag: assert property (
      fullstep_out == (microstep_position_out[7:0] == 8'h80))
      else $error("fullstep flag wrong");
   a_step_cause: assert property (moved |->
      $past(step_in, 2) != $past(step_in, 6)) else $error("moved unasked");
   a_step_size: assert property (moved |->
      10'(microstep_position_out - $past(microstep_position_out)) ==
      (10'h001 << mres_q) || 10'($past(microstep_position_out) -
      microstep_position_out) == (10'h001 << mres_q))
      else $error("step size wrong");
endmodule

//--- verif/tb_top.sv
// bench for the stop, sleep and position block
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module tb_top;
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic sleep_reset_pin_in = 1'b1;
   logic encoder_a_input_in = 1'b0;
   logic encoder_b_in = 1'b0;
   logic cfg_we_in = 1'b0;
   stepper_ctl_pkg::config_t cfg_in = '0;
   logic bridge_disable_pin_in, step_in, dir_in, bridge_on_out;
   logic hold_current_out, fullstep_out, standby_out, diag_reset_out;
   logic [4:0] current_level_out;
   logic [9:0] microstep_position_out;
   logic [31:0] enc_count_out;
   stepper_ctl_pkg::drive_state_t state_out;
   logic [9:0] p;
   int n_errors = 0;
   int n_checks = 0;
   always #2.5 mclk_in = ~mclk_in;
   host_model host (.mclk_in(mclk_in), .step_out(step_in),
      .dir_out(dir_in), .bridge_disable_out(bridge_disable_pin_in));
   stepper_stop_sleep dut (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .bridge_disable_pin_in(bridge_disable_pin_in),
      .sleep_reset_pin_in(sleep_reset_pin_in),
      .step_in(step_in),
      .dir_in(dir_in),
      .encoder_a_input_in(encoder_a_input_in),
      .encoder_b_in(encoder_b_in),
      .cfg_we_in(cfg_we_in),
      .cfg_in(cfg_in),
      .bridge_on_out(bridge_on_out),
      .hold_current_out(hold_current_out),
      .current_level_out(current_level_out),
      .microstep_position_out(microstep_position_out),
      .fullstep_out(fullstep_out),
      .enc_count_out(enc_count_out),
      .standby_out(standby_out),
      .diag_reset_out(diag_reset_out),
      .state_out(state_out)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h, not %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic set_cfg(input logic halt, input logic [3:0] m);
      cfg_in.step_halt_en = halt;
      cfg_in.mres = stepper_ctl_pkg::mres_t'(m);
      cfg_we_in = 1'b1;
      cyc(1);
      cfg_we_in = 1'b0;
   endtask
   // settle time covers sync and detect
   task automatic mv(input int n, input logic d, input logic [9:0] e);
      host.move(n, d);
      cyc(6);
      chk(32'(microstep_position_out), 32'(e));
   endtask
   initial begin
      cyc(5);
      chk(32'(diag_reset_out), 32'h1);
      rst_b_in = 1'b1;
      cyc(3);
      chk(32'(microstep_position_out), 32'h0);
      set_cfg(1'b0, 4'h3);
      mv(10, 1'b0, 10'h050);
      chk(32'(fullstep_out), 32'h0);
      mv(6, 1'b0, 10'h080);
      chk(32'(fullstep_out), 32'h1);
      mv(32, 1'b0, 10'h180);
      chk(32'(fullstep_out), 32'h1);
      p = 10'h180;
      for (int m = 0; m < 9; m++) begin
         set_cfg(1'b0, 4'(m));
         p = p + (10'h001 << m);
         mv(1, 1'b0, p);
         p = p - (10'h001 << m);
         mv(1, 1'b1, p);
      end
      host.bridges(1'b0);
      cyc(8);
      chk(32'(bridge_on_out), 32'h1);
      chk(32'(current_level_out), 32'h1f);
      host.bridges(1'b1);
      cyc(8);
      chk(32'(bridge_on_out), 32'h0);
      chk(32'(current_level_out), 32'h0);
      // hold delay of zero: standstill level at once
      cfg_in.standstill_current = 5'h0a;
      set_cfg(1'b1, 4'h3);
      host.bridges(1'b0);
      encoder_a_input_in = 1'b1;
      cyc(6);
      mv(2, 1'b0, p);
      chk(32'(state_out), 32'(stepper_ctl_pkg::ST_HOLD));
      chk(32'(hold_current_out), 32'h1);
      chk(32'(current_level_out), 32'h0a);
      encoder_a_input_in = 1'b0;
      cyc(6);
      p = p + 10'h010;
      mv(2, 1'b0, p);
      sleep_reset_pin_in = 1'b0;
      cyc(5900);
      sleep_reset_pin_in = 1'b1;
      cyc(10);
      chk(32'(diag_reset_out), 32'h0);
      p = p + 10'h008;
      mv(1, 1'b0, p);
      sleep_reset_pin_in = 1'b0;
      cyc(6100);
      chk(32'(standby_out), 32'h1);
      chk(32'(diag_reset_out), 32'h1);
      chk(32'(bridge_on_out), 32'h0);
      chk(32'(microstep_position_out), 32'h0);
      host.bridges(1'b1);
      sleep_reset_pin_in = 1'b1;
      cyc(10);
      chk(32'(diag_reset_out), 32'h0);
      chk(32'(standby_out), 32'h0);
      mv(1, 1'b0, 10'h001);
      mv(1, 1'b1, 10'h000);
      // decimal 25.6 is 0x0019_9999 in 16.16
      cfg_in.decimal_mode = 1'b1;
      cfg_in.enc_scale = 32'h0019_1770;
      set_cfg(1'b0, 4'h6);
      mv(16, 1'b0, 10'h000);
      encoder_a_input_in = 1'b1;
      cyc(4);
      encoder_b_in = 1'b1;
      cyc(4);
      chk(enc_count_out, 32'h0033_3332);
      encoder_b_in = 1'b0;
      cyc(4);
      chk(enc_count_out, 32'h0019_9999);
      end_of_test();
   end
   initial begin
      #150000;
      n_errors++;
      end_of_test();
   end
endmodule
bind stepper_stop_sleep stepper_props props (.*);
